// ---- common/jtb_consts.vh ----
// Purpose: constants shared by the boundary-scan test port
// Assumes: included by its bare name from hw/ design files
// Notes: state codes are plain binary, one per controller state
`ifndef JTB_CONSTS_VH
`define JTB_CONSTS_VH

// Controller states
`define JTB_ST_RESET 4'h0
`define JTB_ST_IDLE 4'h1
`define JTB_ST_SELDR 4'h2
`define JTB_ST_CAPDR 4'h3
`define JTB_ST_SHDR 4'h4
`define JTB_ST_EX1DR 4'h5
`define JTB_ST_PAUDR 4'h6
`define JTB_ST_EX2DR 4'h7
`define JTB_ST_UPDR 4'h8
`define JTB_ST_SELIR 4'h9
`define JTB_ST_CAPIR 4'hA
`define JTB_ST_SHIR 4'hB
`define JTB_ST_EX1IR 4'hC
`define JTB_ST_PAUIR 4'hD
`define JTB_ST_EX2IR 4'hE
`define JTB_ST_UPIR 4'hF

// Instruction codes
`define JTB_OP_EXTEST 3'h0
`define JTB_OP_IDCODE 3'h1
`define JTB_OP_SAMPLE 3'h2
`define JTB_OP_BYPASS 3'h7
`define JTB_IR_CAPT 3'h1

// Data register selection
`define JTB_SEL_BSR 2'h0
`define JTB_SEL_ID 2'h1
`define JTB_SEL_BYP 2'h2

// Levels and fixed bits
`define JTB_PULL_LVL 1'h1
`define JTB_ID_LSB 1'h1
`define JTB_BYP_CAPT 1'h0

`endif

// ---- hw/jtb_tap_fsm.v ----
// Purpose: sixteen-state test controller, stepped once per test clock rise
// Assumes: tckRise is a one-cycle pulse aligned with a sampled tms
// Notes: scan reset forces the reset state without the clock
`timescale 1ns/1ps
`default_nettype none
`include "jtb_consts.vh"

module jtb_tap_fsm (
   input wire clock,          // System clock
   input wire rstScan_n,      // Scan reset, active low
   input wire tckRise,        // Test clock rising edge pulse
   input wire tms,            // Sampled mode select
   output reg [3:0] state_r   // Current controller state
);

   reg [3:0] state_nxt;

   // Standard transition table on the sampled mode select
   always @* begin
      case (state_r)
         `JTB_ST_RESET: state_nxt = tms ? `JTB_ST_RESET : `JTB_ST_IDLE;
         `JTB_ST_IDLE: state_nxt = tms ? `JTB_ST_SELDR : `JTB_ST_IDLE;
         `JTB_ST_SELDR: state_nxt = tms ? `JTB_ST_SELIR : `JTB_ST_CAPDR;
         `JTB_ST_CAPDR: state_nxt = tms ? `JTB_ST_EX1DR : `JTB_ST_SHDR;
         `JTB_ST_SHDR: state_nxt = tms ? `JTB_ST_EX1DR : `JTB_ST_SHDR;
         `JTB_ST_EX1DR: state_nxt = tms ? `JTB_ST_UPDR : `JTB_ST_PAUDR;
         `JTB_ST_PAUDR: state_nxt = tms ? `JTB_ST_EX2DR : `JTB_ST_PAUDR;
         `JTB_ST_EX2DR: state_nxt = tms ? `JTB_ST_UPDR : `JTB_ST_SHDR;
         `JTB_ST_UPDR: state_nxt = tms ? `JTB_ST_SELDR : `JTB_ST_IDLE;
         `JTB_ST_SELIR: state_nxt = tms ? `JTB_ST_RESET : `JTB_ST_CAPIR;
         `JTB_ST_CAPIR: state_nxt = tms ? `JTB_ST_EX1IR : `JTB_ST_SHIR;
         `JTB_ST_SHIR: state_nxt = tms ? `JTB_ST_EX1IR : `JTB_ST_SHIR;
         `JTB_ST_EX1IR: state_nxt = tms ? `JTB_ST_UPIR : `JTB_ST_PAUIR;
         `JTB_ST_PAUIR: state_nxt = tms ? `JTB_ST_EX2IR : `JTB_ST_PAUIR;
         `JTB_ST_EX2IR: state_nxt = tms ? `JTB_ST_UPIR : `JTB_ST_SHIR;
         `JTB_ST_UPIR: state_nxt = tms ? `JTB_ST_SELDR : `JTB_ST_IDLE;
         default: state_nxt = `JTB_ST_RESET;
      endcase
   end

   // Advance only on a test clock rise
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         state_r <= `JTB_ST_RESET; // RQ20
      end else if (tckRise) begin
         state_r <= state_nxt; // RQ2
      end
   end

endmodule // jtb_tap_fsm
`default_nettype wire

// ---- hw/jtb_tap_top.v ----
// Purpose: boundary-scan test port with controller, instruction and data registers
// Assumes: test clock far slower than clock, at least 4 clock periods per phase
// Notes: all test pins are oversampled; nothing runs on the test clock itself
//        test reset asserts at once and releases on the clock
//        unknown instruction codes fall back to bypass
//        boundary chain: input cells low, output cells high
//        identification fields are arbitrary parameter values
//
// Behaviour
// RQ1 - Four test inputs, one serial output
// RQ2 - Mode select sampled each test clock rise
// RQ3 - Mode select and data idle high
// RQ4 - Serial data sampled on test clock rise
// RQ5 - Serial data goes to instruction or data
// RQ6 - Serial output changes on falling edge
// RQ7 - Output released when not shifting
// RQ8 - Test reset clears whole scan structure
// RQ9 - Scanning never disturbs functional logic
// RQ10 - Controller makes capture, shift, update controls
// RQ11 - Three-bit serially loaded instruction register
// RQ12 - Code 000 drives pins from scan
// RQ13 - Code 010 samples on rise, preloads on fall
// RQ14 - Code 001 identification, default after reset
// RQ15 - Code 111 single-bit bypass path
// RQ16 - Internal test and self-test absent
// RQ17 - Boundary, bypass and identification data registers
// RQ18 - Identification: version, part, maker, one
// RQ19 - Version carries part revision only
// RQ20 - Sixteen-state controller, asynchronous test reset
// RQ21 - Bypass captures zero; unused codes bypass
// RQ22 - Tester changes inputs away from rise
`timescale 1ns/1ps
`default_nettype none
`include "jtb_consts.vh"

module jtb_tap_top #(
   parameter NIN = 4,                 // Boundary input cells
   parameter NOUT = 4,                // Boundary output cells
   parameter [3:0] ID_VERSION = 4'h1, // Part revision, arbitrary value
   parameter [15:0] ID_PART = 16'h1234, // Part number, arbitrary value
   parameter [10:0] ID_MAKER = 11'h2AB  // Maker code, arbitrary value
) (
   input wire clock,                 // System clock, 40 MHz
   input wire rst_n,                 // Asynchronous reset, active low
   input wire tckPin,                // Test clock pin
   input wire tmsPin,                // Test mode select pin
   input wire tdiPin,                // Test data in pin
   input wire trstPin_n,             // Test reset pin, active low
   output wire tdo,                  // Test data out
   output wire tdoOe,                // Test data out drive enable
   input wire [NIN-1:0] padIn,       // Levels at input pins
   input wire [NOUT-1:0] coreOut,    // Functional output values
   output wire [NOUT-1:0] padOut,    // Values driven to output pins
   output wire [NIN-1:0] coreIn      // Values presented to the core
);

   localparam BLEN = NIN + NOUT;
   localparam [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, `JTB_ID_LSB};

   // Data register chosen by an instruction; unknown codes fall to bypass
   // Reserved codes give no pin isolation, so a stray code is harmless
   function [1:0] drSelect;
      input [2:0] op;
      begin
         case (op)
            `JTB_OP_EXTEST: drSelect = `JTB_SEL_BSR; // RQ12
            `JTB_OP_SAMPLE: drSelect = `JTB_SEL_BSR; // RQ13
            `JTB_OP_IDCODE: drSelect = `JTB_SEL_ID; // RQ14
            default: drSelect = `JTB_SEL_BYP; // RQ15 RQ16 RQ21
         endcase
      end
   endfunction

   // True in either shift state; the driver is enabled only there
   function isShift;
      input [3:0] st;
      begin
         isShift = (st == `JTB_ST_SHIR) || (st == `JTB_ST_SHDR);
      end
   endfunction

   // Reset, edge pulses and decoded selections
   wire scanArst_n;
   wire rstScan_n;
   wire tckRise;
   wire tckFall;
   wire tmsS;
   wire tdiS;
   wire [3:0] tapState;
   wire [1:0] curSel;
   wire extestOn;

   // Synchronised test pins and pads
   reg [1:0] trstSync_r;
   reg [1:0] tckSync_r;
   reg tckLast_r;
   reg [1:0] tmsSync_r;
   reg [1:0] tdiSync_r;
   reg [NIN-1:0] padInS1_r;
   reg [NIN-1:0] padInS2_r;

   // Instruction and data registers
   reg [2:0] irShift_r;
   reg [2:0] irActive_r;
   reg bypass_r;
   reg [31:0] idShift_r;
   reg [BLEN-1:0] bsShift_r;
   reg [BLEN-1:0] bsUpd_r;

   // Output flops
   reg tdo_r;
   reg tdoOe_r;
   reg tdo_nxt;
   reg [NOUT-1:0] padOut_r;
   reg [NIN-1:0] coreIn_r;

   // Test reset asserts at once, releases through two flops
   // Synchronised release so no scan flop leaves reset mid-edge
   // Functional reset also forces the scan side back to test-logic-reset
   assign scanArst_n = rst_n & trstPin_n;

   always @(posedge clock or negedge scanArst_n) begin
      if (!scanArst_n) begin
         trstSync_r <= 2'h0; // RQ8
      end else begin
         trstSync_r <= {trstSync_r[0], 1'h1};
      end
   end

   assign rstScan_n = trstSync_r[1]; // RQ8

   // Test pin synchronisers; idle level matches the pad pull-ups
   // Reset to the pull level so no false mode select follows reset
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         tckSync_r <= 2'h0;
         tckLast_r <= 1'h0;
         tmsSync_r <= {2{`JTB_PULL_LVL}}; // RQ3
         tdiSync_r <= {2{`JTB_PULL_LVL}}; // RQ3
      end else begin
         tckSync_r <= {tckSync_r[0], tckPin};
         tckLast_r <= tckSync_r[1];
         tmsSync_r <= {tmsSync_r[0], tmsPin};
         tdiSync_r <= {tdiSync_r[0], tdiPin};
      end
   end

   // Edge pulses; mode select and data share the clock's delay
   // Three clocks of latency; limits how fast the test clock may run
   assign tckRise = tckSync_r[1] & ~tckLast_r;
   assign tckFall = ~tckSync_r[1] & tckLast_r;
   assign tmsS = tmsSync_r[1];
   assign tdiS = tdiSync_r[1];

   // Controller, stepped on sampled test clock rises
   jtb_tap_fsm u_fsm (
      .clock(clock),
      .rstScan_n(rstScan_n),
      .tckRise(tckRise),
      .tms(tmsS),
      .state_r(tapState)
   );

   assign curSel = drSelect(irActive_r);
   assign extestOn = (irActive_r == `JTB_OP_EXTEST);

   // Instruction register: capture, shift on rise; update on fall
   // Shift copy and active copy split so pins hold during a shift
   // Test-logic-reset reloads identification at every fall it sees
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         irShift_r <= `JTB_IR_CAPT;
         irActive_r <= `JTB_OP_IDCODE; // RQ14 RQ8
      end else begin
         if (tckRise) begin
            if (tapState == `JTB_ST_CAPIR) begin
               irShift_r <= `JTB_IR_CAPT; // RQ10
            end else if (tapState == `JTB_ST_SHIR) begin
               irShift_r <= {tdiS, irShift_r[2:1]}; // RQ11 RQ4 RQ5
            end
         end
         if (tckFall) begin
            if (tapState == `JTB_ST_RESET) begin
               irActive_r <= `JTB_OP_IDCODE; // RQ14
            end else if (tapState == `JTB_ST_UPIR) begin
               irActive_r <= irShift_r; // RQ11
            end
         end
      end
   end

   // Bypass bit: zero on capture, one stage when shifting
   // Other registers hold their contents while bypass is chosen
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         bypass_r <= `JTB_BYP_CAPT;
      end else if (tckRise && curSel == `JTB_SEL_BYP) begin
         if (tapState == `JTB_ST_CAPDR) begin
            bypass_r <= `JTB_BYP_CAPT; // RQ21
         end else if (tapState == `JTB_ST_SHDR) begin
            bypass_r <= tdiS; // RQ15 RQ4
         end
      end
   end

   // Identification: fixed word loaded on capture, shifted out LSB first
   // Shifted-in bits are thrown away at the next capture
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         idShift_r <= 32'h0;
      end else if (tckRise && curSel == `JTB_SEL_ID) begin
         if (tapState == `JTB_ST_CAPDR) begin
            idShift_r <= ID_VALUE; // RQ18 RQ19
         end else if (tapState == `JTB_ST_SHDR) begin
            idShift_r <= {tdiS, idShift_r[31:1]}; // RQ5
         end
      end
   end

   // Boundary chain: low cells are inputs, high cells are outputs
   // Capture sees output cells as driven, not raw core values
   // Input cells take synchronised pins to avoid metastable capture
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         bsShift_r <= {BLEN{1'h0}};
      end else if (tckRise && curSel == `JTB_SEL_BSR) begin
         if (tapState == `JTB_ST_CAPDR) begin
            bsShift_r <= {padOut_r, padInS2_r}; // RQ13
         end else if (tapState == `JTB_ST_SHDR) begin
            bsShift_r <= {tdiS, bsShift_r[BLEN-1:1]}; // RQ17
         end
      end
   end

   // Boundary update latches: preload or extest values land on the fall
   // Pins move only on update, never during the shift itself
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         bsUpd_r <= {BLEN{1'h0}};
      end else if (tckFall && tapState == `JTB_ST_UPDR && curSel == `JTB_SEL_BSR) begin
         bsUpd_r <= bsShift_r; // RQ13 RQ12
      end
   end

   // Serial output source for the current state
   // Holds the last bit outside shift so the pin settles quietly
   always @* begin
      tdo_nxt = tdo_r;
      if (tapState == `JTB_ST_SHIR) begin
         tdo_nxt = irShift_r[0];
      end else if (tapState == `JTB_ST_SHDR) begin
         case (curSel)
            `JTB_SEL_BSR: tdo_nxt = bsShift_r[0];
            `JTB_SEL_ID: tdo_nxt = idShift_r[0];
            default: tdo_nxt = bypass_r;
         endcase
      end
   end

   // Output changes on the fall so the tester reads it at the rise
   // Half a test clock of margin before the tester samples
   always @(posedge clock or negedge rstScan_n) begin
      if (!rstScan_n) begin
         tdo_r <= 1'h0;
         tdoOe_r <= 1'h0; // RQ7
      end else if (tckFall) begin
         tdo_r <= tdo_nxt; // RQ6 RQ22
         tdoOe_r <= isShift(tapState); // RQ7
      end
   end

   // Input pins pass two flops before the chain sees them, and a third before the core does
   // One copy feeds both core path and chain, keeping them aligned
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         padInS1_r <= {NIN{1'h0}};
         padInS2_r <= {NIN{1'h0}};
      end else begin
         padInS1_r <= padIn;
         padInS2_r <= padInS1_r;
      end
   end

   // Pin mux: only extest cuts the core off; other codes leave it alone
   // One clock of pin latency, traded for outputs straight from flops
   // Reserved codes keep the functional path, as sample does
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         padOut_r <= {NOUT{1'h0}};
         coreIn_r <= {NIN{1'h0}};
      end else if (extestOn) begin
         padOut_r <= bsUpd_r[BLEN-1:NIN]; // RQ12
         coreIn_r <= bsUpd_r[NIN-1:0]; // RQ12
      end else begin
         padOut_r <= coreOut; // RQ9
         coreIn_r <= padInS2_r; // RQ9
      end
   end

   assign tdo = tdo_r; // RQ1
   assign tdoOe = tdoOe_r;
   assign padOut = padOut_r;
   assign coreIn = coreIn_r;

endmodule // jtb_tap_top
`default_nettype wire

// ---- bench/jtb_tap_chk.sv ----
// Purpose: port checker for the boundary-scan test port
// Assumes: test clock phases of at least 4 clocks
// Notes: timing is judged from the last sampled test clock fall
`timescale 1ns/1ps
`default_nettype none
module jtb_tap_chk #(
   parameter NIN = 4, // Boundary input cells
   parameter NOUT = 4 // Boundary output cells
) (
   input wire clock, // System clock
   input wire rst_n, // Reset, active low
   input wire tckPin, // Test clock pin
   input wire tmsPin, // Mode select pin
   input wire tdiPin, // Data in pin
   input wire trstPin_n, // Test reset, active low
   input wire tdo, // Data out
   input wire tdoOe, // Data out enable
   input wire [NIN-1:0] padIn, // Input pins
   input wire [NOUT-1:0] coreOut, // Core outputs
   input wire [NOUT-1:0] padOut, // Output pins
   input wire [NIN-1:0] coreIn // Core inputs
);
   logic tckD_r;
   logic [3:0] fallCnt_r;
   // Cycles since a pin fall; saturates so idle time reads as old
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tckD_r <= 1'h0;
         fallCnt_r <= 4'hF;
      end else begin
         tckD_r <= tckPin;
         fallCnt_r <= (tckD_r && !tckPin) ? 4'h0 : fallCnt_r + {3'h0, fallCnt_r != 4'hF};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_tdoMove;
      $changed(tdo) && trstPin_n && $past(trstPin_n, 2) |-> fallCnt_r inside {[2:5]};
   endproperty
   a_tdoMove: assert property (p_tdoMove) else $error("tdo moved away from a fall");
   property p_oeMove;
      $changed(tdoOe) && trstPin_n && $past(trstPin_n, 2) |-> fallCnt_r inside {[2:5]};
   endproperty
   a_oeMove: assert property (p_oeMove) else $error("tdoOe moved away from a fall");
   property p_oeHold;
      $rose(tdoOe) |=> (tdoOe || !trstPin_n) [*6];
   endproperty
   a_oeHold: assert property (p_oeHold) else $error("tdoOe pulse too short");
   property p_trstOff;
      !trstPin_n |=> !tdoOe && !tdo;
   endproperty
   a_trstOff: assert property (p_trstOff) else $error("test reset left tdo driven");
   property p_trstQuiet;
      $rose(trstPin_n) |-> !tdoOe ##1 !tdoOe ##1 !tdoOe;
   endproperty
   a_trstQuiet: assert property (p_trstQuiet) else $error("tdoOe after test reset");
   property p_highQuiet;
      tckPin && $past(tckPin, 2) && trstPin_n && $past(trstPin_n, 2) |-> $stable(tdo) && $stable(tdoOe);
   endproperty
   a_highQuiet: assert property (p_highQuiet) else $error("tdo moved while tck high");
   property p_padPath;
      $changed(padOut) |-> padOut == $past(coreOut) || fallCnt_r inside {[1:6]};
   endproperty
   a_padPath: assert property (p_padPath) else $error("padOut from neither core nor scan");
   property p_corePath;
      $changed(coreIn) |-> coreIn == $past(padIn, 3) || fallCnt_r inside {[1:6]};
   endproperty
   a_corePath: assert property (p_corePath) else $error("coreIn from neither pins nor scan");
   c_shift: cover property ($rose(tdoOe));
   c_scanPad: cover property ($changed(padOut) && fallCnt_r inside {[1:6]});
   c_trst: cover property ($fell(trstPin_n));
endmodule // jtb_tap_chk
bind jtb_tap_top jtb_tap_chk #(.NIN(NIN), .NOUT(NOUT)) u_chk (.clock(clock), .rst_n(rst_n),
   .tckPin(tckPin), .tmsPin(tmsPin), .tdiPin(tdiPin), .trstPin_n(trstPin_n), .tdo(tdo),
   .tdoOe(tdoOe), .padIn(padIn), .coreOut(coreOut), .padOut(padOut), .coreIn(coreIn));
`default_nettype wire

// ---- bench/jtb_tester.sv ----
// Purpose: external test controller model
// Assumes: tdo valid 4 clocks after a fall
// Notes: tck stands low between steps
`timescale 1ns/1ps
`default_nettype none
module jtb_tester (
   input wire logic clock, // System clock, paces every pin change
   output logic tck, // Test clock
   output logic tms, // Mode select
   output logic tdi, // Data in
   input wire logic tdo, // Data out
   input wire logic tdoOe, // Data out enable
   output logic stb, // Sample pulse
   output logic bitV // Sampled bit
);
   // Idle levels match the pull-ups
   initial begin
      tck <= 1'h0;
      tms <= 1'h1;
      tdi <= 1'h1;
      stb <= 1'h0;
      bitV <= 1'h0;
   end
   // One 200 ns period of 8 clocks; called at a clock edge, ends at one
   // Pins move only on the low phase start, well away from the rise
   task automatic step(input logic m, input logic d);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clock);
      tck <= 1'h1;
      repeat (3) @(posedge clock);
      bitV <= tdoOe ? tdo : ~tdo;
      stb <= tdoOe;
      @(posedge clock);
      tck <= 1'h0;
      stb <= 1'h0;
   endtask
endmodule // jtb_tester
`default_nettype wire

// ---- bench/tb_jtag_boundary_scan_tap.sv ----
// Purpose: self-checking bench for the test port
// Assumes: tester model steps the test clock
// Notes: tdo bits are queued by the driver and popped by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_jtag_boundary_scan_tap;
   localparam logic [31:0] ID = {4'h1, 16'h1234, 11'h2AB, 1'h1};
   logic clock = 1'h0;
   logic rst_n = 1'h0;
   logic trstPin_n = 1'h0;
   logic [3:0] padIn = 4'h0;
   logic [3:0] coreOut = 4'h0;
   wire logic tck, tms, tdi, tdo, tdoOe, stb, bitV;
   wire logic [3:0] padOut, coreIn;
   logic q[$];
   string what = "reset";
   int bad_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [31:0] rng = 32'hC486;
   logic [31:0] pre;
   jtb_tap_top #(.ID_VERSION(4'h1), .ID_PART(16'h1234), .ID_MAKER(11'h2AB)) dut (.clock(clock),
      .rst_n(rst_n), .tckPin(tck), .tmsPin(tms), .tdiPin(tdi), .trstPin_n(trstPin_n), .tdo(tdo),
      .tdoOe(tdoOe), .padIn(padIn), .coreOut(coreOut), .padOut(padOut), .coreIn(coreIn));
   jtb_tester tester (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
      .stb(stb), .bitV(bitV));
   always #12.5 clock = ~clock;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk1(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chkv(input string nm, input logic [3:0] e, input logic [3:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic exp_bits(input int n, input logic [31:0] v);
      for (int i = 0; i < n; i++) q.push_back(v[i]);
   endtask
   // Idle to Idle through one scan; last bit leaves with tms high
   task automatic scan(input logic ir, input int n, input logic [31:0] din);
      if (ir) tester.step(1'h1, 1'h0);
      tester.step(1'h1, 1'h0);
      tester.step(1'h0, 1'h0);
      tester.step(1'h0, 1'h0);
      for (int i = 0; i < n; i++) tester.step(i == n - 1, din[i]);
      tester.step(1'h1, 1'h0);
      tester.step(1'h0, 1'h0);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Each bit seen with the driver enabled is matched with the oldest note
   always @(posedge clock) begin
      if (stb && q.size() == 0) chk1("tdo extra bit", 1'h0, 1'h1);
      else if (stb) chk1(what, q.pop_front(), bitV);
   end
   // Hang guard, far above the roughly 1700 cycles needed
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      repeat (16) @(posedge clock);
      rst_n <= 1'h1;
      trstPin_n <= 1'h1;
      repeat (6) @(posedge clock);
      tester.step(1'h0, 1'h0);
      what = "idcode";
      exp_bits(32, ID);
      scan(1'h0, 32, 32'h0);
      $display("done %s", what);
      what = "bypass";
      rng = xs(rng);
      exp_bits(3, 32'h1);
      scan(1'h1, 3, 32'h7);
      exp_bits(9, {rng[30:0], 1'h0});
      scan(1'h0, 9, rng);
      for (int c = 3; c < 7; c++) begin
         exp_bits(3, 32'h1);
         scan(1'h1, 3, c);
         exp_bits(2, {rng[30:0], 1'h0});
         scan(1'h0, 2, rng);
      end
      $display("done %s", what);
      what = "sample";
      @(posedge clock);
      rng = xs(rng);
      padIn <= rng[3:0];
      coreOut <= rng[7:4];
      pre = xs(rng);
      exp_bits(3, 32'h1);
      scan(1'h1, 3, 32'h2);
      chkv("padOut", coreOut, padOut);
      exp_bits(8, {24'h0, coreOut, padIn});
      scan(1'h0, 8, pre);
      $display("done %s", what);
      what = "extest";
      exp_bits(3, 32'h1);
      scan(1'h1, 3, 32'h0);
      chkv("padOut", pre[7:4], padOut);
      chkv("coreIn", pre[3:0], coreIn);
      exp_bits(8, {24'h0, pre[7:4], padIn});
      scan(1'h0, 8, ~pre);
      chkv("padOut", ~pre[7:4], padOut);
      $display("done %s", what);
      what = "trst";
      @(posedge clock);
      trstPin_n <= 1'h0;
      repeat (4) @(posedge clock);
      trstPin_n <= 1'h1;
      repeat (4) @(posedge clock);
      chkv("padOut", coreOut, padOut);
      tester.step(1'h0, 1'h0);
      exp_bits(32, ID);
      scan(1'h0, 32, 32'h0);
      chk1("queue empty", 1'h1, q.size() == 0);
      $display("done %s", what);
      end_sim();
   end
endmodule // tb_jtag_boundary_scan_tap
`default_nettype wire
